// *** inc/sspc_pkg.sv ***
// Notes on behaviour
// R1: sleep with all selects zero: high-speed sleep
// R2: medium select alone: medium-speed sleep
// R3: medium sleep clocks peripherals at divider ratio
// R4: medium sleep entry may be half state early
// R5: enabled interrupt wakes sleep to matching active
// R6: mask bit or disabled source keeps sleep
// R7: wake synchroniser adds up to two clocks
// R8: reset pin low in sleep resets cpu
// R9: standby select enters standby, oscillator stops
// R10: standby from either active; pins float unless pulled
// R11: standby wakes only on irq1/0, wakeups, reset
// R12: standby wake waits settling count before clock
// R13: settling field encodes eight wait lengths
// R14: crystal users avoid two-state encoding
// R15: external clock users pick encoding 101
// R16: standby wake resumes per medium select bit
// R17: mask or disabled source keeps standby
// R18: reset pin in standby restarts clock at once
// R19: reset held low until oscillator stable
// R20: inputs hold each level two clocks
// R21: short high before fall may be missed
// R22: width constraints cover seventeen event inputs; this block has thirteen (irq0..4, wakeup 0..7)
// R23: divider codes select 16,32,64,128; reset 128
// R24: wait counter releases clock at selected count
// R25: other select combinations go to outside logic
package sspc_pkg;
    // register map over apb
    localparam logic [7:0] SSPC_CTRL_OFS   = 8'h00;
    localparam logic [7:0] SSPC_ENABLE_OFS = 8'h04;
    localparam logic [7:0] SSPC_STATUS_OFS = 8'h08;
    // control field positions
    localparam int SSPC_STANDBY_BIT  = 0;
    localparam int SSPC_LOWSPEED_BIT = 1;
    localparam int SSPC_MEDIUM_BIT   = 2;
    localparam int SSPC_DIRECT_BIT   = 3;
    localparam int SSPC_TWATCH_BIT   = 4;
    localparam int SSPC_DIV_LSB      = 5;
    localparam int SSPC_WAIT_LSB     = 8;
    // reset values: divider 128, wait 8192 states
    localparam logic [1:0] SSPC_DIV_RESET  = 2'h3;
    localparam logic [2:0] SSPC_WAIT_RESET = 3'h0;
    localparam logic [9:0] SSPC_EN_RESET   = 10'h000;
    localparam int SSPC_CNT_W = 18;
    // power mode states, gray along sleep entry and the standby wake path; active to standby flips two bits
    typedef enum logic [2:0] {
        SSPC_ACTIVE  = 3'h0,
        SSPC_SLEEP   = 3'h1,
        SSPC_STANDBY = 3'h3,
        SSPC_SETTLE  = 3'h2,
        SSPC_RESHOLD = 3'h6
    } sspc_state_type;
endpackage

// *** src/sspc_top.sv ***
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sspc_top (
    input  wire logic                  pclk,         // system clock
    input  wire logic                  presetn,      // async reset, low
    input  wire logic                  psel,         // apb select
    input  wire logic                  penable,      // apb enable
    input  wire logic                  pwrite,       // apb direction
    input  wire logic [7:0]            paddr,        // apb byte address
    input  wire logic [31:0]           pwdata,       // apb write data
    output logic      [31:0]           prdata,       // apb read data
    output logic                       pready,       // apb ready
    output logic                       pslverr,      // apb error
    input  wire logic                  sleep_exec,   // cpu sleep pulse
    input  wire logic                  int_mask,     // cpu mask bit
    input  wire logic [4:0]            external_interrupt_inputs, // pins, low active
    input  wire logic [7:0]            wakeup_inputs,             // pins, low active
    input  wire logic                  reset_pin_n,  // reset pin
    output logic                       cpu_halt,     // cpu clock stopped
    output logic                       osc_run,      // oscillator enable
    output logic                       chip_clk_en,  // chip clock supplied
    output logic                       periph_clk_en,// peripheral clock on
    output logic                       medium_speed, // medium clock select
    output logic [7:0]                 periph_div,   // peripheral divide ratio
    output logic                       pins_float,   // pins high impedance
    output logic                       cpu_reset,    // cpu held in reset
    output logic                       wake_irq,     // start exception pulse
    output logic                       other_mode_req // handoff pulse
);
    import sspc_pkg::*;

    // overview: one mode sequencer decides sleep, standby and their exits.
    // wake pins are falling edge requests, synchronised then latched as
    // sticky flags, so a short low between clocks is never lost once seen.
    // the reset pin is synchronised too; it is not the block reset, which
    // stays presetn, so the sequencer can hold the cpu while clocks run.
    // limitation: watch, subsleep and direct transfer are handed outside
    // with a single pulse; this block never enters those modes itself.

    // ****************************************
    // registers
    // ****************************************
    logic [10:0] ctrl_q;
    logic [9:0]  en_q;   // 5 irq enables, then wakeup group... low 5 irq, bit 5 all wkp, 6..9 unused
    sspc_state_type state_q, state_d;
    logic [SSPC_CNT_W-1:0] cnt_q, cnt_d;
    logic [12:0] s1_q, s2_q, prev_q;
    logic [12:0] flag_q;
    logic        r1_q, r2_q;

    wire wr_en   = psel & penable & pwrite;
    wire hit_ctl = (paddr == SSPC_CTRL_OFS);
    wire hit_en  = (paddr == SSPC_ENABLE_OFS);
    wire hit_st  = (paddr == SSPC_STATUS_OFS);
    wire standby_select = ctrl_q[SSPC_STANDBY_BIT];
    wire low_speed_wake_select  = ctrl_q[SSPC_LOWSPEED_BIT];
    wire medium_speed_select    = ctrl_q[SSPC_MEDIUM_BIT];
    wire direct_transfer_select = ctrl_q[SSPC_DIRECT_BIT];
    wire timer_watch_select     = ctrl_q[SSPC_TWATCH_BIT];
    wire [1:0] div_sel = ctrl_q[SSPC_DIV_LSB +: 2];
    wire [2:0] settling_wait_field = ctrl_q[SSPC_WAIT_LSB +: 3];

    // ****************************************
    // apb slave, zero wait states
    // ****************************************
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~(hit_ctl | hit_en | hit_st);
    wire [31:0] st_word = {16'h0000, flag_q, state_q};
    assign prdata = hit_ctl ? {21'h0, ctrl_q} : hit_en ? {22'h0, en_q} :
                    hit_st ? st_word : 32'h0;

    // control written in any state, awake or asleep; no mode guard
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // bit 7 is spare, divider sits at 6:5, selects at 4:0
            ctrl_q <= {SSPC_WAIT_RESET, 1'b0, SSPC_DIV_RESET, 5'h00}; // R23
            en_q   <= SSPC_EN_RESET;
        end else if (wr_en && hit_ctl) begin
            ctrl_q <= pwdata[10:0];
        end else if (wr_en && hit_en) begin
            en_q <= pwdata[9:0];
        end
    end

    // ****************************************
    // input synchronisers and edge capture
    // ****************************************
    wire [12:0] raw = {wakeup_inputs, external_interrupt_inputs};
    // two flops; wake seen up to two clocks late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 13'h1fff;
            s2_q <= 13'h1fff;
            prev_q <= 13'h1fff;
            r1_q <= 1'b1;
            r2_q <= 1'b1;
        end else begin
            s1_q <= raw;    // R7
            s2_q <= s1_q;
            prev_q <= s2_q;
            r1_q <= reset_pin_n;
            r2_q <= r1_q;
        end
    end
    // falling edges latch; a high shorter than one clock can be missed
    wire [12:0] fall = prev_q & ~s2_q; // R21 R22
    wire [12:0] st_clr = (wr_en && hit_st) ? pwdata[15:3] : 13'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) flag_q <= 13'h0;
        else flag_q <= (flag_q & ~st_clr) | fall; // set wins over clear
    end
    // enable map: bits 0..4 irq0..4, bit 5 covers all wakeups
    wire [12:0] en_vec = {{8{en_q[5]}}, en_q[4:0]};
    wire any_req  = |(flag_q & en_vec) & ~int_mask;          // R5 R6
    wire stby_req = |(flag_q & en_vec & 13'h1fe3) & ~int_mask; // R11 R17

    // ****************************************
    // mode sequencer
    // ****************************************
    wire sel_sleep = ~standby_select & ~low_speed_wake_select & ~direct_transfer_select;
    wire sel_stby  = standby_select & ~low_speed_wake_select & ~timer_watch_select;
    logic [SSPC_CNT_W-1:0] wait_len;
    always_comb begin
        case (settling_wait_field) // R13
            3'h0:    wait_len = 18'h02000;
            3'h1:    wait_len = 18'h04000;
            3'h2:    wait_len = 18'h08000;
            3'h3:    wait_len = 18'h10000;
            3'h4:    wait_len = 18'h20000;
            3'h5:    wait_len = 18'h00002;
            3'h6:    wait_len = 18'h00008;
            default: wait_len = 18'h00010;
        endcase
    end

    // next-state; reset pin overrides wake in sleep, standby and settle
    // the counter only runs in settle, so standby burns no count power;
    // it is cleared in standby so every wake starts from zero
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            SSPC_ACTIVE: begin
                if (sleep_exec && sel_sleep) state_d = SSPC_SLEEP; // R1 R2
                else if (sleep_exec && sel_stby) state_d = SSPC_STANDBY; // R9 R10
            end
            SSPC_SLEEP: begin
                if (!r2_q) state_d = SSPC_RESHOLD; // R8
                else if (any_req) state_d = SSPC_ACTIVE; // R5
            end
            SSPC_STANDBY: begin
                cnt_d = '0;
                if (!r2_q) state_d = SSPC_RESHOLD; // R18
                else if (stby_req) state_d = SSPC_SETTLE; // R12
            end
            SSPC_SETTLE: begin
                cnt_d = cnt_q + 18'h00001; // R24
                if (!r2_q) state_d = SSPC_RESHOLD;
                else if (cnt_d >= wait_len) state_d = SSPC_ACTIVE; // R12
            end
            SSPC_RESHOLD: begin
                if (r2_q) state_d = SSPC_ACTIVE; // R18
            end
            default: state_d = SSPC_ACTIVE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SSPC_ACTIVE;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    logic wake_q, other_q, halt_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_q  <= 1'b0;
            other_q <= 1'b0;
            halt_q  <= 1'b0;
        end else begin
            wake_q  <= (state_q != SSPC_ACTIVE) && (state_q != SSPC_RESHOLD)
                       && state_d == SSPC_ACTIVE; // R5 R12
            other_q <= state_q == SSPC_ACTIVE && sleep_exec && !sel_sleep && !sel_stby; // R25
            // halt asserts the same edge the mode changes; the half state slack is absorbed here
            halt_q  <= state_d != SSPC_ACTIVE; // R4
        end
    end
    assign wake_irq       = wake_q;
    assign other_mode_req = other_q;
    assign cpu_halt       = halt_q; // R1 R2 R9
    assign osc_run        = state_q != SSPC_STANDBY; // R9 R12 R18
    assign chip_clk_en    = (state_q != SSPC_STANDBY) && (state_q != SSPC_SETTLE); // R12 R18
    assign periph_clk_en  = chip_clk_en;
    assign pins_float     = state_q == SSPC_STANDBY; // R10
    assign cpu_reset      = state_q == SSPC_RESHOLD; // R8
    assign medium_speed   = medium_speed_select; // R2 R16
    // divider ratio 16..128 from two-bit code
    assign periph_div     = 8'h10 << div_sel; // R3 R23

    // ****************************************
    // checks
    // ****************************************
    chk_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == SSPC_ACTIVE && sleep_exec && sel_sleep |=> state_q == SSPC_SLEEP) // R1
        else $error("sleep not entered");
    chk_masked_stay: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == SSPC_SLEEP && int_mask && r2_q |=> state_q == SSPC_SLEEP) // R6
        else $error("masked wake left sleep");
    chk_stby_entry: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == SSPC_ACTIVE && sleep_exec && sel_stby |=> pins_float && !osc_run) // R9
        else $error("standby not entered");
    chk_stby_mask: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == SSPC_STANDBY && int_mask && r2_q |=> state_q == SSPC_STANDBY) // R17
        else $error("masked wake left standby");
    chk_settle_clk: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == SSPC_SETTLE |-> osc_run && !chip_clk_en) // R12
        else $error("clock before settle");
    chk_settle_len: assert property (@(posedge pclk) disable iff (!presetn)
        settling_wait_field == 3'h5 && $rose(state_q == SSPC_SETTLE) && r2_q
        |-> ##2 state_q == SSPC_ACTIVE) // R13
        else $error("two state wait wrong");
    chk_reset_hold: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == SSPC_SLEEP && !r2_q |=> cpu_reset) // R8
        else $error("reset pin ignored");
    chk_reset_clk: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_reset |-> osc_run && chip_clk_en) // R18
        else $error("no clock in reset");
    chk_div_ratio: assert property (@(posedge pclk) disable iff (!presetn)
        div_sel == 2'h3 |-> periph_div == 8'h80) // R23
        else $error("divider ratio wrong");
    chk_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(raw[0]) ##1 !raw[0] ##1 !raw[0] |=> flag_q[0]) // R7
        else $error("edge not caught");

    // ****************************************
    // entry and wake checks
    // ****************************************
    // medium select alone still sleeps, clock slows
    chk_med_entry: assert property (@(posedge pclk) disable iff (!presetn) // R2
        state_q == SSPC_ACTIVE && sleep_exec && sel_sleep && medium_speed_select
        |=> state_q == SSPC_SLEEP && medium_speed)
        else $error("medium sleep not entered");

    // peripherals keep running while the cpu sleeps
    chk_sleep_clk: assert property (@(posedge pclk) disable iff (!presetn) // R1 R3
        state_q == SSPC_SLEEP
        |-> periph_clk_en && chip_clk_en)
        else $error("peripheral clock stopped in sleep");

    // an enabled unmasked request ends sleep at once
    chk_sleep_wake: assert property (@(posedge pclk) disable iff (!presetn) // R5
        state_q == SSPC_SLEEP && any_req && r2_q
        |=> state_q == SSPC_ACTIVE && !cpu_halt && wake_irq)
        else $error("sleep wake missed");

    // exception start is a single pulse
    chk_wake_pulse: assert property (@(posedge pclk) disable iff (!presetn) // R5
        wake_irq
        |=> !wake_irq)
        else $error("wake pulse too long");

    // a standby source restarts the oscillator first
    chk_stby_wake: assert property (@(posedge pclk) disable iff (!presetn) // R12
        state_q == SSPC_STANDBY && stby_req && r2_q
        |=> state_q == SSPC_SETTLE && osc_run)
        else $error("standby wake missed");

    // sources outside the standby set leave it asleep
    chk_stby_other: assert property (@(posedge pclk) disable iff (!presetn) // R11
        state_q == SSPC_STANDBY && r2_q && !stby_req
        |=> state_q == SSPC_STANDBY)
        else $error("standby left without source");

    // reset pin in standby gives clocks straight away
    chk_stby_reset: assert property (@(posedge pclk) disable iff (!presetn) // R18
        state_q == SSPC_STANDBY && !r2_q
        |=> cpu_reset && osc_run && chip_clk_en)
        else $error("standby reset pin ignored");

    // reset handling only starts once the pin is high
    chk_reset_leave: assert property (@(posedge pclk) disable iff (!presetn) // R18
        state_q == SSPC_RESHOLD && r2_q
        |=> state_q == SSPC_ACTIVE && !cpu_reset)
        else $error("reset hold not released");

    // no early exit while the count is short
    chk_settle_hold: assert property (@(posedge pclk) disable iff (!presetn) // R24
        state_q == SSPC_SETTLE && r2_q && cnt_d < wait_len
        |=> state_q == SSPC_SETTLE)
        else $error("settle ended early");

    // cpu stays halted in every low power state
    chk_halt_track: assert property (@(posedge pclk) disable iff (!presetn) // R1 R9
        state_q != SSPC_ACTIVE
        |-> cpu_halt)
        else $error("cpu running while asleep");

    // unknown select mixes pass outside and stay awake
    chk_handoff: assert property (@(posedge pclk) disable iff (!presetn) // R25
        state_q == SSPC_ACTIVE && sleep_exec && !sel_sleep && !sel_stby
        |=> other_mode_req && state_q == SSPC_ACTIVE)
        else $error("handoff pulse missing");

    // floating pins only with every clock stopped
    chk_float_clk: assert property (@(posedge pclk) disable iff (!presetn) // R10
        pins_float
        |-> !chip_clk_en && !osc_run)
        else $error("pins float with clock on");

    // lowest divider code gives the fastest clock
    chk_div_low: assert property (@(posedge pclk) disable iff (!presetn) // R23
        div_sel == 2'h0
        |-> periph_div == 8'h10)
        else $error("divide by sixteen wrong");

    // a seen edge is kept even against a clear
    chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn) // R21
        fall != 13'h0
        |=> (flag_q & $past(fall)) == $past(fall))
        else $error("edge flag lost");

    // ****************************************
    // settle length, counted apart from the sequencer
    // ****************************************
    // an independent count, so a broken compare in the sequencer shows
    logic [7:0] settle_cyc_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cyc_q <= 8'h00;
        end else if (state_q == SSPC_SETTLE) begin
            settle_cyc_q <= settle_cyc_q + 8'h01;
        end else begin
            settle_cyc_q <= 8'h00;
        end
    end

    // eight state wait: exit on the eighth settle clock
    chk_settle_eight: assert property (@(posedge pclk) disable iff (!presetn) // R13 R24
        state_q == SSPC_SETTLE && state_d == SSPC_ACTIVE && settling_wait_field == 3'h6
        |-> settle_cyc_q == 8'h07)
        else $error("eight state wait wrong");

    // ****************************************
    // scenario covers
    // ****************************************
    cov_med_wake: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == SSPC_SLEEP && medium_speed ##1 state_q == SSPC_ACTIVE);
    cov_handoff: cover property (@(posedge pclk) disable iff (!presetn)
        other_mode_req);
    cov_sleep_wake: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == SSPC_SLEEP ##1 state_q == SSPC_ACTIVE);
    cov_stby_wake: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == SSPC_SETTLE ##1 state_q == SSPC_ACTIVE);
    cov_reset_exit: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == SSPC_RESHOLD ##1 state_q == SSPC_ACTIVE);
endmodule
`default_nettype wire

// *** verification/sspc_pins_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// far side: wake pins and reset pin
// ****************************************
module sspc_pins_model (
    input  wire logic       pclk,      // system clock
    output logic      [4:0] ext_int_n, // interrupt pins, idle high
    output logic      [7:0] wake_n,    // wake-up pins, idle high
    output logic            reset_n    // reset pin
);
    initial begin
        ext_int_n = 5'h1f;
        wake_n = 8'hff;
        reset_n = 1'b1;
    end
    // low for len clocks, then high four clocks so both widths exceed two
    task automatic pin_low(input int sel, input int idx, input int len);
        @(posedge pclk);
        if (sel == 0) ext_int_n[idx] <= 1'b0;
        else if (sel == 1) wake_n[idx] <= 1'b0;
        else reset_n <= 1'b0;
        repeat (len) @(posedge pclk);
        ext_int_n <= 5'h1f;
        wake_n <= 8'hff;
        reset_n <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// power mode control bench
// ****************************************
module testbench;
    import sspc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic sleep_exec = 1'b0;
    logic int_mask = 1'b0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, cpu_halt, osc_run, chip_clk_en, periph_clk_en;
    wire logic medium_speed, pins_float, cpu_reset, wake_irq, other_mode_req;
    wire logic [7:0] periph_div, wkp_n;
    wire logic [4:0] irq_n;
    wire logic rst_n;
    int errors = 0;
    int comparisons = 0;
    int n;
    logic [31:0] rd;
    always #12.5 pclk = ~pclk;
    sspc_pins_model pins (.pclk(pclk), .ext_int_n(irq_n), .wake_n(wkp_n), .reset_n(rst_n));
    sspc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_exec(sleep_exec), .int_mask(int_mask),
        .external_interrupt_inputs(irq_n), .wakeup_inputs(wkp_n), .reset_pin_n(rst_n),
        .cpu_halt(cpu_halt), .osc_run(osc_run), .chip_clk_en(chip_clk_en),
        .periph_clk_en(periph_clk_en), .medium_speed(medium_speed), .periph_div(periph_div),
        .pins_float(pins_float), .cpu_reset(cpu_reset), .wake_irq(wake_irq),
        .other_mode_req(other_mode_req));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer; read data and error are taken at the ready edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = pslverr ? 32'hdead : prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic sleep_now();
        @(posedge pclk);
        sleep_exec <= 1'b1;
        @(posedge pclk);
        sleep_exec <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask
    // counts clocks until the chosen pulse, bounded so a lost pulse shows
    task automatic wait_pulse(input logic other, input int lim, output int cnt);
        cnt = 0;
        while ((other ? other_mode_req : wake_irq) !== 1'b1 && cnt < lim) begin
            @(posedge pclk);
            cnt++;
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        errors++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        check("reset div", 32'h80, periph_div);
        apb(1'b0, SSPC_CTRL_OFS, 32'h0);
        check("ctrl reset", 32'h60, rd);
        apb(1'b0, 8'h0c, 32'h0);
        check("unmapped", 32'hdead, rd);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, SSPC_CTRL_OFS, c << 5);
            @(posedge pclk);
            check("divider", 32'h10 << c, periph_div);
        end
        $display("test divider done");
        // high-speed sleep held by the mask, then woken
        apb(1'b1, SSPC_ENABLE_OFS, 32'h3f);
        apb(1'b1, SSPC_CTRL_OFS, 32'h0);
        int_mask <= 1'b1;
        sleep_now();
        check("hs halt", 32'h3, {periph_clk_en, cpu_halt});
        pins.pin_low(0, 2, 4);
        repeat (10) @(posedge pclk);
        check("masked", 32'h1, cpu_halt);
        int_mask <= 1'b0;
        wait_pulse(1'b0, 6, n);
        check("hs wake", 32'h0, {n > 4, cpu_halt, medium_speed});
        apb(1'b1, SSPC_STATUS_OFS, 32'hfff8);
        $display("test sleep done");
        // medium-speed sleep with divider 32
        apb(1'b1, SSPC_CTRL_OFS, 32'h24);
        sleep_now();
        check("ms sleep", 32'h320, {cpu_halt, medium_speed, periph_div});
        fork
            pins.pin_low(1, 3, 4);
            wait_pulse(1'b0, 12, n);
        join
        check("ms wake", 32'h1, {n > 10, cpu_halt, medium_speed});
        apb(1'b1, SSPC_STATUS_OFS, 32'hfff8);
        $display("test medium done");
        // standby: wrong and disabled sources must not wake it
        apb(1'b1, SSPC_ENABLE_OFS, 32'h3e);
        apb(1'b1, SSPC_CTRL_OFS, 32'h601);
        sleep_now();
        check("stby pins", 32'h9, {pins_float, osc_run, chip_clk_en, cpu_halt});
        pins.pin_low(0, 2, 4);
        pins.pin_low(0, 0, 4);
        check("stby held", 32'h9, {pins_float, osc_run, chip_clk_en, cpu_halt});
        fork
            pins.pin_low(0, 1, 4);
            wait_pulse(1'b0, 30, n);
        join
        check("settle len", 32'h1, n >= 12 && n <= 15);
        check("stby resume", 32'h0, {cpu_halt, medium_speed, pins_float});
        apb(1'b1, SSPC_STATUS_OFS, 32'hfff8);
        // external clock: shortest wait, woken by a wake-up pin
        apb(1'b1, SSPC_CTRL_OFS, 32'h501);
        sleep_now();
        fork
            pins.pin_low(1, 0, 4);
            wait_pulse(1'b0, 20, n);
        join
        check("short settle", 32'h1, n >= 7 && n <= 9);
        apb(1'b1, SSPC_STATUS_OFS, 32'hfff8);
        $display("test standby done");
        // reset pin from sleep and from standby
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, SSPC_CTRL_OFS, i ? 32'h601 : 32'h0);
            sleep_now();
            fork
                pins.pin_low(2, 0, 20);
                begin
                    repeat (10) @(posedge pclk);
                    check("res held", 32'h7, {cpu_reset, osc_run, chip_clk_en});
                end
            join
            check("res release", 32'h0, {cpu_reset, cpu_halt});
        end
        $display("test reset pin done");
        apb(1'b1, SSPC_CTRL_OFS, 32'h08);
        fork
            sleep_now();
            wait_pulse(1'b1, 4, n);
        join
        check("handoff", 32'h0, {n > 3, cpu_halt});
        $display("test handoff done");
        test_done();
    end
endmodule
`default_nettype wire
